/* File: logic/hwsv_top.sv */
// Host watchdog and safe value command interpreter with APB registers
// How it works
// R1: read_watchdog_timeout_cmd answers address, enable digit, two hex digits.
// R2: Enable digit reads 0 when disabled, 1 when enabled.
// R3: Timeout counts tenths of a second, 01 to FF; code also accepts 00 and resets to 00.
// R4: set_watchdog_cmd sets enable and timeout together.
// R5: Enable digit 0 disables, 1 enables the watchdog.
// R6: Valid replies start with '!', rejected ones with '?', then address.
// R7: Malformed, errored or foreign-address frames get no reply.
// R8: Address field is two hex digits, 00 to FF.
// R9: Timeout clears enable; host must set it again.
// R10: read_digital_default_bitmaps_cmd returns power-on then safe bitmap.
// R11: Bitmap bit n is digital channel n, 1 active.
// R12: Alarm channels ignore power-on and safe bitmaps.
// R13: read_analog_safe_value_cmd returns stored safe value of channel 0 or 1.
// R14: Nonexistent analog channel gets the invalid reply.
// R15: store_analog_safe_value_cmd copies present analog value into safe storage.
// R16: Store channel digit is zero based, only 0 and 1.
// R17: Broadcast host-alive frame accepted, never answered.
// R18: Status byte: bit 2 timeout occurred, bit 7 enabled.
// R19: Timeout flag cleared only by the status-reset command.
// R20: Host-alive restarts count; timeout after programmed tenths.
// R21: Bitmap read versus analog safe read told apart by frame length.
`timescale 1ns/1ps
module hwsv_top #(
  parameter int TENTH_CYCLES = hwsv_pkg::TENTH_CYCLES,
  parameter logic [7:0] ADDR_DEFAULT = hwsv_pkg::ADDR_RESET
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wd_enabled,
  output logic wd_timeout_flag,
  output logic reply_pending,
  output logic [7:0] do_power_on,
  output logic [7:0] do_safe
);
  import hwsv_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] to_hex(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      return {1'b1, c[3:0] + 4'h9};
    return 5'h00;
  endfunction

  // ==========================================================
  // APB slave, no wait states
  logic acc;
  logic wr_ok;
  logic rd_ok;
  logic mapped;
  logic [7:0] own_addr;
  logic [7:0] bm_power_on;
  logic [7:0] bm_safe;
  logic [7:0] alarm_mask;
  logic [15:0] ao_now [2];
  logic [15:0] ao_safe [2];
  logic [7:0] status;
  logic [7:0] rbuf [REPLY_MAX];
  logic [3:0] rlen;
  logic [3:0] ridx;
  logic tx_valid;
  logic [31:0] rdata;
  logic addr_loaded;
  logic tick;
  logic act;
  logic wd_flag;
  hwsv_wd_if wd ();

  assign acc = psel && penable && pready;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_AOSAFE);
  assign wr_ok = acc && pwrite && mapped;
  assign rd_ok = acc && !pwrite && mapped;
  assign tx_valid = (ridx < rlen);

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      OFS_ADDR: rdata = {24'h0, own_addr};
      OFS_TX: rdata = {23'h0, tx_valid, tx_valid ? rbuf[ridx] : 8'h00};
      OFS_WDSTAT: rdata = {16'h0, wd.tenths, status};
      OFS_DOMAP: rdata = {8'h0, alarm_mask, bm_safe, bm_power_on};
      OFS_AO0: rdata = {16'h0, ao_now[0]};
      OFS_AO1: rdata = {16'h0, ao_now[1]};
      OFS_AOSAFE: rdata = {ao_safe[1], ao_safe[0]};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr <= 8'h00;
      bm_power_on <= 8'h00;
      bm_safe <= 8'h00;
      alarm_mask <= 8'h00;
      ao_now[0] <= 16'h0000;
      ao_now[1] <= 16'h0000;
    end else if (wr_ok) begin
      case (paddr)
        OFS_ADDR: own_addr <= pwdata[7:0];
        OFS_DOMAP: begin
          bm_power_on <= pwdata[7:0];
          bm_safe <= pwdata[15:8];
          alarm_mask <= pwdata[23:16];
        end
        OFS_AO0: ao_now[0] <= pwdata[15:0];
        OFS_AO1: ao_now[1] <= pwdata[15:0];
        default: ;
      endcase
    end else if (own_addr == 8'h00 && !addr_loaded) begin
      own_addr <= ADDR_DEFAULT;
    end
  end

  // Default address is taken after reset release, not under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) addr_loaded <= 1'b0;
    else addr_loaded <= 1'b1;
  end

  // ==========================================================
  // Frame collector
  hwsv_pstate_t pstate;
  logic [7:0] fb [FRAME_MAX];
  logic [2:0] flen;
  logic go;
  logic rx_wr;
  logic [7:0] rx_ch;

  assign rx_wr = wr_ok && (paddr == OFS_RX);
  assign rx_ch = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate <= PS_IDLE;
      flen <= 3'd0;
      go <= 1'b0;
    end else begin
      go <= 1'b0;
      if (rx_wr) begin
        if (rx_ch == CH_START) begin
          pstate <= pwdata[RX_ERR_BIT] ? PS_DROP : PS_COLLECT;
          flen <= 3'd0;
        end else begin
          case (pstate)
            PS_COLLECT: begin
              if (pwdata[RX_ERR_BIT]) begin
                pstate <= PS_DROP; // R7
              end else if (rx_ch == CH_CR) begin
                go <= 1'b1;
                pstate <= PS_IDLE;
              end else if (flen == 3'(FRAME_MAX)) begin
                pstate <= PS_DROP; // R7
              end else begin
                fb[flen] <= rx_ch;
                flen <= flen + 3'd1;
              end
            end
            PS_DROP: if (rx_ch == CH_CR) pstate <= PS_IDLE;
            PS_IDLE: pstate <= PS_IDLE;
            default: pstate <= PS_IDLE;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Decoder
  logic d_reply;
  logic d_ok;
  logic d_kick;
  logic d_set;
  logic d_clear;
  logic d_store;
  logic d_ch;
  logic [2:0] d_n;
  logic [7:0] d_dat [4];
  logic [4:0] a_hi;
  logic [4:0] a_lo;
  logic [4:0] p3;
  logic [4:0] p4;
  logic [4:0] p5;

  assign status = {wd.en, 4'h0, wd_flag, 2'b00}; // R18

  always_comb begin
    a_hi = hex_val(fb[0]);
    a_lo = hex_val(fb[1]);
    p3 = hex_val(fb[3]);
    p4 = hex_val(fb[4]);
    p5 = hex_val(fb[5]);
    d_reply = 1'b0;
    d_ok = 1'b1;
    d_kick = 1'b0;
    d_set = 1'b0;
    d_clear = 1'b0;
    d_store = 1'b0;
    d_ch = fb[3][0];
    d_n = 3'd0;
    for (int i = 0; i < 4; i++) d_dat[i] = 8'h00;
    if (flen == 3'd2 && fb[0] == CH_ALL && fb[1] == CH_ALL) begin
      d_kick = 1'b1; // R17
    end else if (flen >= 3'd3 && a_hi[4] && a_lo[4] &&
                 {a_hi[3:0], a_lo[3:0]} == own_addr) begin // R7 R8
      d_reply = 1'b1;
      case (fb[2])
        CMD_STATE: begin
          d_reply = (flen == 3'd3);
          d_n = 3'd2;
          d_dat[0] = to_hex(status[7:4]); // R18
          d_dat[1] = to_hex(status[3:0]);
        end
        CMD_CLEAR: begin
          d_reply = (flen == 3'd3);
          d_clear = 1'b1; // R19
        end
        CMD_READ_WD: begin
          d_reply = (flen == 3'd3); // R1
          d_n = 3'd3;
          d_dat[0] = wd.en ? 8'h31 : 8'h30; // R2
          d_dat[1] = to_hex(wd.tenths[7:4]); // R3
          d_dat[2] = to_hex(wd.tenths[3:0]);
        end
        CMD_SET_WD: begin
          d_reply = (flen == 3'd6) && p4[4] && p5[4]; // R4
          d_ok = (fb[3] == 8'h30) || (fb[3] == 8'h31); // R5
          d_set = 1'b1;
        end
        CMD_READ_SAFE: begin
          if (flen == 3'd3) begin // R21
            d_n = 3'd4; // R10
            d_dat[0] = to_hex(bm_power_on[7:4]);
            d_dat[1] = to_hex(bm_power_on[3:0]);
            d_dat[2] = to_hex(bm_safe[7:4]);
            d_dat[3] = to_hex(bm_safe[3:0]);
          end else begin
            d_reply = (flen == 3'd4) && p3[4]; // R21
            d_ok = (p3[3:0] < AO_CHANNELS); // R14
            d_n = 3'd4; // R13
            d_dat[0] = to_hex(ao_safe[d_ch][15:12]);
            d_dat[1] = to_hex(ao_safe[d_ch][11:8]);
            d_dat[2] = to_hex(ao_safe[d_ch][7:4]);
            d_dat[3] = to_hex(ao_safe[d_ch][3:0]);
          end
        end
        CMD_STORE_SAFE: begin
          d_reply = (flen == 3'd4) && p3[4];
          d_ok = (p3[3:0] < AO_CHANNELS); // R14 R16
          d_store = 1'b1;
        end
        default: d_ok = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Actions and reply
  assign act = go && d_reply && d_ok;
  assign wd.set = act && d_set;
  assign wd.set_en = fb[3][0];
  assign wd.set_tenths = {p4[3:0], p5[3:0]};
  assign wd.kick = go && d_kick; // R20

  hwsv_tick #(.CYCLES(TENTH_CYCLES)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clear(wd.kick || wd.set),
    .tick(tick)
  );

  hwsv_wdog u_wdog (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .wd(wd.dog)
  );

  // Expiry wins over a clear arriving in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_flag <= 1'b0;
    else if (wd.expired) wd_flag <= 1'b1;
    else if (act && d_clear) wd_flag <= 1'b0; // R19
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ao_safe[0] <= 16'h0000;
      ao_safe[1] <= 16'h0000;
    end else if (act && d_store) begin
      ao_safe[d_ch] <= ao_now[d_ch]; // R15
    end
  end

  // A new reply replaces any unread one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rlen <= 4'd0;
      ridx <= 4'd0;
    end else if (go && d_reply) begin
      rbuf[0] <= d_ok ? CH_OK : CH_BAD; // R6
      rbuf[1] <= to_hex(own_addr[7:4]); // R8
      rbuf[2] <= to_hex(own_addr[3:0]);
      for (int i = 0; i < 4; i++) begin
        if (d_ok && 3'(i) < d_n) rbuf[3 + i] <= d_dat[i];
      end
      rbuf[d_ok ? 4'd3 + {1'b0, d_n} : 4'd3] <= CH_CR;
      rlen <= d_ok ? 4'd4 + {1'b0, d_n} : 4'd4;
      ridx <= 4'd0;
    end else if (rd_ok && paddr == OFS_TX && tx_valid) begin
      ridx <= ridx + 4'd1;
    end
  end

  // ==========================================================
  // Pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_enabled <= 1'b0;
      wd_timeout_flag <= 1'b0;
      reply_pending <= 1'b0;
      do_power_on <= 8'h00;
      do_safe <= 8'h00;
    end else begin
      wd_enabled <= wd.en;
      wd_timeout_flag <= wd_flag;
      reply_pending <= tx_valid;
      do_power_on <= bm_power_on & ~alarm_mask; // R11 R12
      do_safe <= bm_safe & ~alarm_mask; // R11 R12
    end
  end
endmodule

/* File: logic/hwsv_pkg.sv */
// Constants shared by the host watchdog and safe value command block
package hwsv_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_RX = 8'h04;
  localparam logic [7:0] OFS_TX = 8'h08;
  localparam logic [7:0] OFS_WDSTAT = 8'h0C;
  localparam logic [7:0] OFS_DOMAP = 8'h10;
  localparam logic [7:0] OFS_AO0 = 8'h14;
  localparam logic [7:0] OFS_AO1 = 8'h18;
  localparam logic [7:0] OFS_AOSAFE = 8'h1C;
  // ==========================================================
  // Field positions and reset values
  localparam int RX_ERR_BIT = 8;
  localparam int TX_VALID_BIT = 8;
  localparam int ST_TIMEOUT_BIT = 2;
  localparam int ST_ENABLE_BIT = 7;
  localparam logic [7:0] ADDR_RESET = 8'h01;
  localparam logic [7:0] TENTHS_RESET = 8'h00;
  // ==========================================================
  // Frame characters and sizes
  localparam logic [7:0] CH_START = 8'h7E;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_OK = 8'h21;
  localparam logic [7:0] CH_BAD = 8'h3F;
  localparam logic [7:0] CH_ALL = 8'h2A;
  localparam logic [7:0] CMD_STATE = 8'h30;
  localparam logic [7:0] CMD_CLEAR = 8'h31;
  localparam logic [7:0] CMD_READ_WD = 8'h32;
  localparam logic [7:0] CMD_SET_WD = 8'h33;
  localparam logic [7:0] CMD_READ_SAFE = 8'h34;
  localparam logic [7:0] CMD_STORE_SAFE = 8'h35;
  localparam int FRAME_MAX = 7;
  localparam int REPLY_MAX = 10;
  localparam logic [3:0] AO_CHANNELS = 4'h2;
  // ==========================================================
  // Timing
  localparam longint CLK_PERIOD_PS = 5000;
  localparam longint TENTH_S_PS = 64'd100000000000;
  localparam int TENTH_CYCLES = int'(TENTH_S_PS / CLK_PERIOD_PS);
  // ==========================================================
  // Parser states
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_COLLECT = 2'b01,
    PS_DROP = 2'b10
  } hwsv_pstate_t;
endpackage

/* File: logic/hwsv_wd_if.sv */
// Control and status wires between the parser and the watchdog counter
`timescale 1ns/1ps
interface hwsv_wd_if;
  logic set;
  logic set_en;
  logic [7:0] set_tenths;
  logic kick;
  logic en;
  logic [7:0] tenths;
  logic expired;
  modport ctl (output set, set_en, set_tenths, kick,
               input en, tenths, expired);
  modport dog (input set, set_en, set_tenths, kick,
               output en, tenths, expired);
endinterface

/* File: logic/hwsv_tick.sv */
// Tenth-of-a-second enable pulse divider
`timescale 1ns/1ps
module hwsv_tick #(
  parameter int CYCLES = hwsv_pkg::TENTH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  output logic tick
);
  import hwsv_pkg::*;
  localparam int W = $clog2(CYCLES);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] cnt;

  if (CYCLES < 2) begin : g_bad
    $error("hwsv_tick: CYCLES must be at least 2");
  end

  // Restart on kick so a period always starts at the host's last sign
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (clear) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + W'(1);
    end
  end
endmodule

/* File: logic/hwsv_wdog.sv */
// Host watchdog: enable, timeout in tenths and expiry detection
`timescale 1ns/1ps
module hwsv_wdog (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  hwsv_wd_if.dog wd
);
  import hwsv_pkg::*;
  logic [7:0] elapsed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd.en <= 1'b0;
      wd.tenths <= TENTHS_RESET;
    end else if (wd.set) begin
      wd.en <= wd.set_en; // R5
      wd.tenths <= wd.set_tenths; // R4
    end else if (wd.expired) begin
      wd.en <= 1'b0; // R9
    end
  end

  // A timeout of 00 expires at the first tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed <= 8'h00;
      wd.expired <= 1'b0;
    end else begin
      wd.expired <= 1'b0;
      if (wd.set || wd.kick || !wd.en) begin
        elapsed <= 8'h00; // R20
      end else if (tick) begin
        if (9'(elapsed) + 9'h001 >= 9'(wd.tenths)) begin
          wd.expired <= 1'b1; // R20
          elapsed <= 8'h00;
        end else begin
          elapsed <= elapsed + 8'h01;
        end
      end
    end
  end
endmodule

/* File: dv/hwsv_chk.sv */
// Port-level assertions for the watchdog command block
`timescale 1ns/1ps
module hwsv_chk
  import hwsv_pkg::*;
#(
  parameter int TENTH_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wd_enabled,
  input wire logic wd_timeout_flag,
  input wire logic reply_pending,
  input wire logic [7:0] do_power_on,
  input wire logic [7:0] do_safe
);
  // =====
  // Recent frame writes and reply pops
  logic [2:0] rx_age;
  logic [2:0] tx_age;
  logic apb_go;
  assign apb_go = psel && penable && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_age <= 3'h0;
    end else if (apb_go && pwrite && paddr == OFS_RX) begin
      rx_age <= 3'h6;
    end else if (rx_age != 3'h0) begin
      rx_age <= rx_age - 3'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_age <= 3'h0;
    end else if (apb_go && !pwrite && paddr == OFS_TX) begin
      tx_age <= 3'h6;
    end else if (tx_age != 3'h0) begin
      tx_age <= tx_age - 3'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====
  // Properties
  property p_ready_once;
    psel && !penable |=> pready && penable;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("access cycle without ready");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held two cycles");
  property p_err_bad;
    pslverr |-> pready && (paddr > OFS_AOSAFE || paddr[1:0] != 2'b00);
  endproperty
  a_err_bad: assert property (p_err_bad)
    else $error("error on a mapped address");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside access");
  property p_expire_off;
    $rose(wd_timeout_flag) |-> ##[0:2] !wd_enabled;
  endproperty
  a_expire_off: assert property (p_expire_off)
    else $error("enable kept after expiry");
  property p_flag_clear;
    $fell(wd_timeout_flag) |-> rx_age != 3'h0;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("timeout flag cleared without a frame");
  property p_en_rise;
    $rose(wd_enabled) |-> rx_age != 3'h0;
  endproperty
  a_en_rise: assert property (p_en_rise)
    else $error("enable set without a frame");
  property p_po_hold;
    $changed(do_power_on) |-> $past(psel && penable && pwrite, 2);
  endproperty
  a_po_hold: assert property (p_po_hold)
    else $error("power-on map moved without a write");
  property p_safe_hold;
    $changed(do_safe) |-> $past(psel && penable && pwrite, 2);
  endproperty
  a_safe_hold: assert property (p_safe_hold)
    else $error("safe map moved without a write");
  property p_pend_fall;
    $fell(reply_pending) |-> tx_age != 3'h0;
  endproperty
  a_pend_fall: assert property (p_pend_fall)
    else $error("reply lost without being read");
  c_expire: cover property ($rose(wd_timeout_flag));
  c_pop: cover property ($fell(reply_pending));
  c_err: cover property (pslverr);
endmodule
bind hwsv_top hwsv_chk #(.TENTH_CYCLES(TENTH_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wd_enabled(wd_enabled),
  .wd_timeout_flag(wd_timeout_flag), .reply_pending(reply_pending),
  .do_power_on(do_power_on), .do_safe(do_safe));

/* File: dv/hwsv_host.sv */
// Host controller model: APB master that frames ASCII commands
`timescale 1ns/1ps
module hwsv_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  import hwsv_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not look like a held request
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic raw(input string s);
    logic [31:0] r;
    logic e;
    for (int i = 0; i < s.len(); i++) begin
      xfer(1'b1, OFS_RX, {24'h0, s[i]}, r, e);
    end
  endtask
  // Address is two hex digits ahead of the command, except in the ** broadcast frame
  task automatic frame(input string s);
    raw({"~", s, "\015"});
    repeat (3) @(posedge pclk);
  endtask
endmodule

/* File: dv/hwsv_top_bench.sv */
// Self-checking bench for the watchdog command block
`timescale 1ns/1ps
module hwsv_top_bench;
  import hwsv_pkg::*;
  localparam int TC = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic wd_enabled, wd_timeout_flag, reply_pending;
  logic [7:0] paddr, do_power_on, do_safe;
  logic [31:0] pwdata, prdata, rd;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2.5 pclk = ~pclk;
  hwsv_top #(.TENTH_CYCLES(TC)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wd_enabled(wd_enabled),
    .wd_timeout_flag(wd_timeout_flag), .reply_pending(reply_pending),
    .do_power_on(do_power_on), .do_safe(do_safe));
  hwsv_host u_host (
    .pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  // =====
  // Helpers
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, rd, er);
    chk(n, e, rd);
  endtask
  // Drains the reply, so a stale one cannot pass for the next
  task automatic reply(input string s);
    chk("pending", {31'h0, s.len() > 0}, {31'h0, reply_pending});
    for (int i = 0; i < s.len(); i++) begin
      rdchk("tx", OFS_TX, {23'h0, 1'b1, s[i]});
    end
    if (s.len() > 0) begin
      rdchk("tx_cr", OFS_TX, {23'h0, 1'b1, CH_CR});
    end
    u_host.xfer(1'b0, OFS_TX, 32'h0, rd, er);
    chk("tx_empty", 32'h0, {31'h0, rd[TX_VALID_BIT]});
    chk("drained", 32'h0, {31'h0, reply_pending});
  endtask
  task automatic cmd(input string c, input string r);
    u_host.frame(c);
    reply(r);
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish;
    end
  end
  // =====
  // Tests
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk("addr", OFS_ADDR, {24'h0, ADDR_RESET});
    rdchk("wdstat", OFS_WDSTAT, 32'h0);
    u_host.xfer(1'b0, 8'h20, 32'h0, rd, er);
    chk("unmapped", 32'h1, {31'h0, er});
    done("reset");
    cmd("012", "!01000");
    cmd("013164", "!01");
    cmd("012", "!01164");
    chk("wd_en", 32'h1, {31'h0, wd_enabled});
    rdchk("wdstat", OFS_WDSTAT, 32'h6480);
    cmd("0130FF", "!01");
    cmd("012", "!010FF");
    done("set");
    cmd("013264", "?01");
    cmd("019", "?01");
    cmd("022", "");
    u_host.raw("~01");
    wr(OFS_RX, 32'h132);
    u_host.raw("\015");
    reply("");
    wr(OFS_ADDR, 32'hFF);
    cmd("FF2", "!FF0FF");
    wr(OFS_ADDR, 32'h01);
    cmd("**", "");
    done("refuse");
    cmd("013102", "!01");
    for (int i = 0; i < 6; i++) begin
      u_host.frame("**");
    end
    chk("kept", 32'h1, {31'h0, wd_enabled});
    repeat (3 * TC) @(posedge pclk);
    chk("expired", 32'h2, {30'h0, wd_timeout_flag, wd_enabled});
    cmd("010", "!0104");
    cmd("012", "!01002");
    cmd("011", "!01");
    cmd("010", "!0100");
    done("expire");
    wr(OFS_DOMAP, 32'h020201);
    cmd("014", "!010102");
    chk("maps", 32'h0100, {16'h0, do_power_on, do_safe});
    done("bitmaps");
    wr(OFS_AO0, 32'h1234);
    wr(OFS_AO1, 32'hABCD);
    cmd("0150", "!01");
    cmd("0151", "!01");
    cmd("0140", "!011234");
    cmd("0141", "!01ABCD");
    cmd("014F", "?01");
    cmd("015F", "?01");
    cmd("0152", "?01");
    rdchk("aosafe", OFS_AOSAFE, 32'hABCD1234);
    done("analog");
    tally_and_finish;
  end
endmodule
